// ### src/mpb_master_pins.sv
// Pin function selection, master clock output and self-boot protocol select for the master ports.
`timescale 1ns/1ps
`include "mpb_defines.svh"
module mpb_master_pins #(
  parameter logic [7:0] REF_HALF_CYCLES = `MPB_REF_HALF_CYCLES,
  parameter logic [2:0] BOOT_SETTLE_CYCLES = `MPB_BOOT_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  // Configuration write port.
  input wire logic cfg_write,
  input wire logic [1:0] cfg_master_mode,
  input wire logic [5:0] cfg_func_sel,
  input wire logic [5:0] cfg_pullup_en,
  input wire logic [1:0] cfg_clk_mult,
  // Internal master engines.
  input wire logic spi_xfer_active,
  input wire logic spi_mosi_data,
  input wire logic spi_sclk,
  input wire logic i2c1_scl_low,
  input wire logic i2c1_sda_low,
  input wire logic i2c2_scl_low,
  input wire logic i2c2_sda_low,
  // General-purpose line controls.
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  // Boot loader handshake.
  input wire logic boot_done,
  // Pads.
  input wire logic boot_from_memory_strap,
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic [5:0] pad_pullup_en,
  output logic master_clock_output,
  // Status toward the core.
  output logic [5:0] line_state,
  output logic boot_start,
  output logic boot_active,
  output logic boot_use_i2c,
  output logic [2:0] mode_state
);

  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  mpb_sync_if #(.WIDTH(7)) sif ();

  // The strap and the six pads share one synchroniser bank.
  assign sif.raw = {boot_from_memory_strap, pad_in};

  mpb_pin_sync #(
    .WIDTH(7),
    .IDLE(`MPB_SYNC_IDLE)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .port(sif.sync_side)
  );

  wire [5:0] pin_now = sif.stable[5:0];
  wire strap_now = sif.stable[`MPB_STRAP_BIT];

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  mpb_pkg::mpb_mode_t mode_reg;
  mpb_pkg::mpb_mode_t mode_dec;
  logic [5:0] func_reg;
  logic [5:0] pullup_reg;
  logic [1:0] mult_reg;

  // Illegal mode codes fall back to general-purpose use.
  assign mode_dec = (cfg_master_mode == `MPB_MODE_CODE_SPI) ? mpb_pkg::MPB_MODE_SPI :
                    (cfg_master_mode == `MPB_MODE_CODE_I2C) ? mpb_pkg::MPB_MODE_I2C :
                    mpb_pkg::MPB_MODE_GPIO;

  // Software settings are held until the next write or reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_reg <= mpb_pkg::MPB_MODE_GPIO;
      func_reg <= `MPB_FUNC_RESET;
      pullup_reg <= `MPB_PULLUP_RESET;
      mult_reg <= `MPB_MULT_RESET;
    end else if (cfg_write) begin
      mode_reg <= mode_dec;
      func_reg <= cfg_func_sel;
      pullup_reg <= cfg_pullup_en;
      mult_reg <= cfg_clk_mult;
    end
  end

  // ****************************************************************
  // Self-boot sequencer.
  // ****************************************************************
  mpb_pkg::mpb_boot_t boot_state_reg;
  mpb_pkg::mpb_boot_t boot_state_next;
  logic [2:0] settle_cnt_reg;
  logic use_i2c_reg;
  logic boot_start_reg;

  // The synchroniser bank holds its idle level through reset, so the settled strap and slave-select levels
  // only show the real pins one edge after the filter first takes them; sampling earlier would read idle ones.
  wire settle_done = (settle_cnt_reg == BOOT_SETTLE_CYCLES);
  wire boot_sampling = (boot_state_reg == mpb_pkg::MPB_BOOT_SETTLE);
  wire boot_take = boot_sampling && settle_done;
  wire boot_go = boot_take && strap_now;
  wire boot_running = (boot_state_reg == mpb_pkg::MPB_BOOT_RUN);

  // Next boot state.
  always_comb begin
    boot_state_next = boot_state_reg;
    unique case (boot_state_reg)
      mpb_pkg::MPB_BOOT_SETTLE: begin
        if (boot_take) begin
          boot_state_next = strap_now ? mpb_pkg::MPB_BOOT_RUN : mpb_pkg::MPB_BOOT_IDLE;
        end
      end
      mpb_pkg::MPB_BOOT_RUN: begin
        if (boot_done) begin
          boot_state_next = mpb_pkg::MPB_BOOT_IDLE;
        end
      end
      mpb_pkg::MPB_BOOT_IDLE: begin
        boot_state_next = mpb_pkg::MPB_BOOT_IDLE;
      end
    endcase
  end

  // Sampling happens once per reset release, on the settled pin levels.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      boot_state_reg <= mpb_pkg::MPB_BOOT_SETTLE;
      settle_cnt_reg <= 3'h0;
      use_i2c_reg <= 1'b0;
      boot_start_reg <= 1'b0;
    end else begin
      boot_state_reg <= boot_state_next;
      boot_start_reg <= boot_go;
      if (boot_sampling && !settle_done) begin
        settle_cnt_reg <= settle_cnt_reg + 3'h1;
      end
      if (boot_go) begin
        use_i2c_reg <= ~pin_now[`MPB_PIN_GPIO_LINE_0];
      end
    end
  end

  // ****************************************************************
  // Effective mode and per-pin master selection.
  // ****************************************************************
  // While booting the loader owns the first master port in the sampled protocol.
  wire [2:0] boot_mode = use_i2c_reg ? mpb_pkg::MPB_MODE_I2C : mpb_pkg::MPB_MODE_SPI;
  wire [2:0] mode_eff = boot_running ? boot_mode : mode_reg;
  wire is_spi = (mode_eff == mpb_pkg::MPB_MODE_SPI);
  wire is_i2c = (mode_eff == mpb_pkg::MPB_MODE_I2C);
  wire [3:0] port1_master = func_reg[3:0] | {4{boot_running}};
  wire [3:0] m_spi = port1_master & {4{is_spi}};
  wire [3:0] m_i2c = port1_master & {4{is_i2c}};
  wire [3:0] port1_gpio = ~(m_spi | m_i2c);
  // The second I2C port only runs when software selects it; booting never uses it.
  wire [1:0] port2_gpio = ~(func_reg[5:4] & {2{mode_reg == mpb_pkg::MPB_MODE_I2C}});

  // ****************************************************************
  // Pad drive selection.
  // ****************************************************************
  wire [5:0] out_next;
  wire [5:0] oe_next;

  // Slave select is low for the whole transaction and high between transactions.
  assign out_next[0] = port1_gpio[0] ? gpio_out[0] : ~spi_xfer_active;
  assign oe_next[0] = port1_gpio[0] ? gpio_oe[0] : m_spi[0];

  // Serial data out to the slaves.
  assign out_next[1] = port1_gpio[1] ? gpio_out[1] : spi_mosi_data;
  assign oe_next[1] = port1_gpio[1] ? gpio_oe[1] : m_spi[1];

  // SPI clock push-pull, or first I2C clock pulled low only.
  assign out_next[2] = port1_gpio[2] ? gpio_out[2] : (m_spi[2] & spi_sclk);
  assign oe_next[2] = port1_gpio[2] ? gpio_oe[2] : (m_spi[2] | i2c1_scl_low);

  // SPI data in is never driven; first I2C data is open drain.
  assign out_next[3] = port1_gpio[3] ? gpio_out[3] : 1'b0;
  assign oe_next[3] = port1_gpio[3] ? gpio_oe[3] : (m_i2c[3] & i2c1_sda_low);

  // Second I2C port clock and data, both open drain.
  assign out_next[4] = port2_gpio[0] ? gpio_out[4] : 1'b0;
  assign oe_next[4] = port2_gpio[0] ? gpio_oe[4] : i2c2_scl_low;
  assign out_next[5] = port2_gpio[1] ? gpio_out[5] : 1'b0;
  assign oe_next[5] = port2_gpio[1] ? gpio_oe[5] : i2c2_sda_low;

  // The slave-select pull-up stays on while the boot protocol is being sampled.
  wire [5:0] pullup_next = pullup_reg | {5'h00, boot_sampling};

  // ****************************************************************
  // Master clock output divider.
  // ****************************************************************
  logic [7:0] clk_cnt_reg;
  logic mclk_reg;

  // Half period shrinks by a power of two for each multiplier step.
  wire [7:0] half_cycles = REF_HALF_CYCLES >> mult_reg;
  wire half_done = (clk_cnt_reg >= half_cycles - 8'h01);

  // Toggling at the end of every half period gives the selected multiple.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_cnt_reg <= 8'h00;
      mclk_reg <= 1'b0;
    end else if (half_done) begin
      clk_cnt_reg <= 8'h00;
      mclk_reg <= ~mclk_reg;
    end else begin
      clk_cnt_reg <= clk_cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Output registers.
  // ****************************************************************
  logic [5:0] pad_out_reg;
  logic [5:0] pad_oe_reg;
  logic [5:0] pad_pullup_reg;
  logic [5:0] line_state_reg;
  logic [2:0] mode_state_reg;

  // Every pad and status output except boot_active, which is decoded from the boot state register, leaves from a flip-flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pad_out_reg <= 6'h00;
      pad_oe_reg <= 6'h00;
      pad_pullup_reg <= `MPB_PULLUP_RESET;
      line_state_reg <= 6'h3F;
      mode_state_reg <= mpb_pkg::MPB_MODE_GPIO;
    end else begin
      pad_out_reg <= out_next;
      pad_oe_reg <= oe_next;
      pad_pullup_reg <= pullup_next;
      line_state_reg <= pin_now;
      mode_state_reg <= mode_eff;
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pad_pullup_en = pad_pullup_reg;
  assign master_clock_output = mclk_reg;
  assign line_state = line_state_reg;
  assign boot_start = boot_start_reg;
  assign boot_active = boot_running;
  assign boot_use_i2c = use_i2c_reg;
  assign mode_state = mode_state_reg;

endmodule

// ### src/mpb_defines.svh
// Constants for the master-port pin and boot-select block.
`ifndef MPB_DEFINES_SVH
`define MPB_DEFINES_SVH

// ****************************************************************
// Pin indices within the six-pin pad vectors, and the strap bit of the seven-bit synchroniser bank.
// ****************************************************************
`define MPB_PIN_COUNT 6
`define MPB_PIN_GPIO_LINE_0 0
`define MPB_PIN_GPIO_LINE_1 1
`define MPB_PIN_GPIO_LINE_2 2
`define MPB_PIN_GPIO_LINE_3 3
`define MPB_PIN_GPIO_LINE_24 4
`define MPB_PIN_GPIO_LINE_25 5
`define MPB_STRAP_BIT 6

// ****************************************************************
// Encodings and reset values.
// ****************************************************************
`define MPB_MODE_CODE_GPIO 2'h0
`define MPB_MODE_CODE_SPI 2'h1
`define MPB_MODE_CODE_I2C 2'h2
`define MPB_FUNC_RESET 6'h00
`define MPB_PULLUP_RESET 6'h3F
`define MPB_MULT_RESET 2'h0
`define MPB_SYNC_IDLE 7'h7F

// ****************************************************************
// Timing counts in clk cycles.
// ****************************************************************
`define MPB_REF_HALF_CYCLES 8'h10
`define MPB_BOOT_SETTLE_CYCLES 3'h4

`endif

// ### src/mpb_pkg.sv
// Types shared by the master-port pin and boot-select modules.
package mpb_pkg;

  // Effective function of the shared master pins.
  typedef enum logic [2:0] {
    MPB_MODE_GPIO = 3'b001,
    MPB_MODE_SPI = 3'b010,
    MPB_MODE_I2C = 3'b100
  } mpb_mode_t;

  // Boot sequencer states.
  typedef enum logic [2:0] {
    MPB_BOOT_SETTLE = 3'b001,
    MPB_BOOT_RUN = 3'b010,
    MPB_BOOT_IDLE = 3'b100
  } mpb_boot_t;

endpackage

// ### src/mpb_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and settled levels back.
`timescale 1ns/1ps
interface mpb_sync_if #(
  parameter int WIDTH = 7
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] stable;

  modport sync_side (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// ### src/mpb_pin_sync.sv
// Three-stage synchroniser bank for pin inputs with a two-stage agreement filter.
`timescale 1ns/1ps
module mpb_pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic resetn,
  mpb_sync_if.sync_side port
);

  // ****************************************************************
  // One synchroniser per pin.
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic stable_reg;
      wire agree = (s2_reg == s3_reg);

      // The first stage feeds only the second; a change counts once stages two and three agree.
      always_ff @(posedge clk) begin
        if (!resetn) begin
          s1_reg <= IDLE[i];
          s2_reg <= IDLE[i];
          s3_reg <= IDLE[i];
          stable_reg <= IDLE[i];
        end else begin
          s1_reg <= port.raw[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree) begin
            stable_reg <= s3_reg;
          end
        end
      end

      assign port.stable[i] = stable_reg;
    end
  endgenerate

endmodule

// ### dv/mpb_slave_model.sv
// Far-side model: slave devices, board pull resistors and resolved pad levels.
`timescale 1ns/1ps
module mpb_slave_model (
  input wire logic clk,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pad_pullup_en,
  input wire logic ss_pulldown,
  input wire logic miso_bit,
  input wire logic [5:0] slave_low,
  output logic [5:0] pad_in
);
  logic [5:0] last_reg = 6'h00;
  // Resolves each pad; a floating pad with no pull shows the inverse of its last level.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (slave_low[i]) begin
        pad_in[i] = 1'b0;
      end else if (i == 3 && pad_oe[0] && !pad_out[0]) begin
        pad_in[i] = miso_bit;
      end else if (i == 0 && ss_pulldown) begin
        pad_in[i] = 1'b0;
      end else if (pad_pullup_en[i] || i > 1) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_reg[i];
      end
    end
  end
  // Remembers the last level for floating pads.
  always_ff @(posedge clk) last_reg <= pad_in;
endmodule

// ### dv/mpb_master_pins_props.sv
// Concurrent checks on the ports of the master-port pin block.
`timescale 1ns/1ps
module mpb_master_pins_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_func_sel,
  input wire logic spi_xfer_active,
  input wire logic spi_mosi_data,
  input wire logic spi_sclk,
  input wire logic i2c1_scl_low,
  input wire logic i2c1_sda_low,
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  input wire logic boot_from_memory_strap,
  input wire logic [5:0] pad_in,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pad_pullup_en,
  input wire logic master_clock_output,
  input wire logic boot_start,
  input wire logic boot_active,
  input wire logic boot_use_i2c,
  input wire logic [2:0] mode_state
);
  // ********
  // Function setting as seen by the pads
  // ********
  logic [5:0] fq1_reg;
  logic [5:0] fq2_reg;
  // Follows the function setting two edges behind its write, as the pads do.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fq1_reg <= 6'h00;
      fq2_reg <= 6'h00;
    end else begin
      fq1_reg <= cfg_write ? cfg_func_sel : fq1_reg;
      fq2_reg <= fq1_reg;
    end
  end
  // Master use of the SPI pads or the first I2C pair outside a boot.
  wire spi_on = mode_state == 3'h2 && fq2_reg[3:0] == 4'hF && !boot_active;
  wire i2c_on = mode_state == 3'h4 && fq2_reg[3:2] == 2'h3 && !boot_active;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_release;
    $rose(resetn);
  endsequence
  sequence s_boot_pulse;
    !boot_start [*5] ##1 boot_start ##1 (!boot_start && boot_active);
  endsequence
  a_reset_defaults: assert property (disable iff (1'b0) !resetn |=> pad_oe == 6'h00 &&
    pad_pullup_en == 6'h3F && mode_state == 3'h1 && !boot_active && !boot_start && !master_clock_output)
    else $error("reset values wrong");
  a_ss_follow: assert property (spi_on && !$past(boot_active) |->
    pad_oe[0] && pad_out[0] == !$past(spi_xfer_active)) else $error("slave select wrong");
  a_spi_out: assert property (spi_on && !$past(boot_active) |->
    pad_out[2:1] == {$past(spi_sclk), $past(spi_mosi_data)} && pad_oe[3:1] == 3'h3) else $error("spi pads wrong");
  a_i2c_first: assert property (i2c_on && !$past(boot_active) |-> pad_out[3:2] == 2'h0 &&
    pad_oe[3:2] == {$past(i2c1_sda_low), $past(i2c1_scl_low)}) else $error("i2c pads wrong");
  a_gpio_follow: assert property ($past(resetn) && !boot_active && !$past(boot_active) |->
    ((pad_out ^ $past(gpio_out)) & ~fq2_reg) == 6'h00 && ((pad_oe ^ $past(gpio_oe)) & ~fq2_reg) == 6'h00)
    else $error("gpio pads wrong");
  a_boot_pulse: assert property (s_release ##0 boot_from_memory_strap |-> s_boot_pulse)
    else $error("boot start wrong");
  a_boot_none: assert property (s_release ##0 !boot_from_memory_strap |-> !boot_start [*8])
    else $error("boot without strap");
  a_boot_proto: assert property (boot_start |-> boot_use_i2c == !$past(pad_in[0], 5))
    else $error("boot protocol wrong");
endmodule
bind mpb_master_pins mpb_master_pins_props mpb_master_pins_props_i (.clk, .resetn, .cfg_write, .cfg_func_sel,
  .spi_xfer_active, .spi_mosi_data, .spi_sclk, .i2c1_scl_low, .i2c1_sda_low, .gpio_out, .gpio_oe,
  .boot_from_memory_strap, .pad_in, .pad_out, .pad_oe, .pad_pullup_en, .master_clock_output, .boot_start,
  .boot_active, .boot_use_i2c, .mode_state);

// ### dv/mpb_master_pins_tb.sv
// Self-checking testbench for the master-port pin and boot-select block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module mpb_master_pins_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_write = 1'b0;
  logic [1:0] cfg_master_mode = 2'h0;
  logic [5:0] cfg_func_sel = 6'h00;
  logic [5:0] cfg_pullup_en = 6'h3F;
  logic [1:0] cfg_clk_mult = 2'h0;
  logic [2:0] spi = 3'h0; // Transfer active, data out, clock.
  logic [3:0] i2c_low = 4'h0; // First clock, first data, second clock, second data.
  logic [5:0] gpio_out = 6'h00;
  logic [5:0] gpio_oe = 6'h00;
  logic boot_done = 1'b0;
  logic strap = 1'b0;
  logic ss_pulldown = 1'b0;
  logic miso_bit = 1'b0;
  logic [5:0] slave_low = 6'h00;
  logic [5:0] pad_in;
  logic [5:0] pad_out;
  logic [5:0] pad_oe;
  logic [5:0] pad_pullup_en;
  logic [5:0] line_state;
  logic master_clock_output;
  logic boot_start;
  logic boot_active;
  logic boot_use_i2c;
  logic [2:0] mode_state;
  int n_errors = 0;
  int checks = 0;
  mpb_master_pins #(.REF_HALF_CYCLES(8'h10), .BOOT_SETTLE_CYCLES(3'h4)) mpb_master_pins_i (.clk(clk),
    .resetn(resetn), .cfg_write(cfg_write), .cfg_master_mode(cfg_master_mode), .cfg_func_sel(cfg_func_sel),
    .cfg_pullup_en(cfg_pullup_en), .cfg_clk_mult(cfg_clk_mult), .spi_xfer_active(spi[0]),
    .spi_mosi_data(spi[1]), .spi_sclk(spi[2]), .i2c1_scl_low(i2c_low[0]), .i2c1_sda_low(i2c_low[1]),
    .i2c2_scl_low(i2c_low[2]), .i2c2_sda_low(i2c_low[3]), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .boot_done(boot_done), .boot_from_memory_strap(strap), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .master_clock_output(master_clock_output), .line_state(line_state),
    .boot_start(boot_start), .boot_active(boot_active), .boot_use_i2c(boot_use_i2c), .mode_state(mode_state));
  mpb_slave_model mpb_slave_model_i (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .ss_pulldown(ss_pulldown), .miso_bit(miso_bit), .slave_low(slave_low), .pad_in(pad_in));
  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ends a run whose wait ran out.
  task automatic give_up();
    n_errors++;
    end_of_test();
  endtask
  // Loads one configuration and lets it reach the pads.
  task automatic cfg(input logic [1:0] m, input logic [5:0] f, input logic [5:0] p, input logic [1:0] x);
    @(posedge clk);
    cfg_write <= 1'b1;
    cfg_master_mode <= m;
    cfg_func_sel <= f;
    cfg_pullup_en <= p;
    cfg_clk_mult <= x;
    @(posedge clk);
    cfg_write <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Resets with a given strap and slave-select pull, then follows the boot.
  task automatic t_boot(input logic s, input logic pd, input logic exp_i2c);
    int k;
    @(posedge clk);
    resetn <= 1'b0;
    strap <= s;
    ss_pulldown <= pd;
    // The core releases its general-purpose drives in reset, leaving the slave-select pin to its pulls.
    gpio_out <= 6'h00;
    gpio_oe <= 6'h00;
    repeat (10) @(posedge clk);
    `CHK("oe in reset", 6'h00, pad_oe)
    `CHK("mode in reset", 3'h1, mode_state)
    resetn <= 1'b1;
    k = 0;
    while (boot_start !== 1'b1 && k < 12) begin
      @(negedge clk);
      k++;
    end
    if (s && k == 12) give_up();
    `CHK("boot start", s, boot_start)
    if (s) `CHK("boot over i2c", exp_i2c, boot_use_i2c)
    @(posedge clk);
    boot_done <= 1'b1;
    @(posedge clk);
    boot_done <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("boot ended", 1'b0, boot_active)
    $display("boot test done");
  endtask
  // Master pads released to general use, mode code 3.
  task automatic t_gpio();
    cfg(2'h3, 6'h00, 6'h15, 2'h0);
    gpio_out <= 6'h2A;
    gpio_oe <= 6'h3F;
    repeat (3) @(negedge clk);
    `CHK("gpio mode", 3'h1, mode_state)
    `CHK("gpio out", 6'h2A, pad_out)
    `CHK("gpio oe", 6'h3F, pad_oe)
    `CHK("pull-ups", 6'h15, pad_pullup_en)
    $display("gpio test done");
  endtask
  // One SPI transaction and its end.
  task automatic t_spi();
    cfg(2'h1, 6'h0F, 6'h3F, 2'h0);
    spi <= 3'h7;
    repeat (7) @(negedge clk);
    `CHK("select low", 2'h2, {pad_oe[0], pad_out[0]})
    `CHK("data and clock", 2'h3, pad_out[2:1])
    `CHK("data in", 1'b0, line_state[3])
    @(posedge clk);
    spi <= 3'h0;
    repeat (7) @(negedge clk);
    `CHK("select high", 3'h1, pad_out[2:0])
    `CHK("data in idle", 1'b1, line_state[3])
    $display("spi test done");
  endtask
  // Both I2C ports with clocks held and slaves pulling data low.
  task automatic t_i2c();
    cfg(2'h2, 6'h3F, 6'h3F, 2'h0);
    i2c_low <= 4'h5;
    slave_low <= 6'h28;
    repeat (7) @(negedge clk);
    `CHK("i2c oe", 6'h14, pad_oe)
    `CHK("i2c drive", 6'h00, pad_out & 6'h3C)
    `CHK("i2c levels", 4'h0, line_state[5:2])
    @(posedge clk);
    i2c_low <= 4'h0;
    slave_low <= 6'h00;
    repeat (7) @(negedge clk);
    `CHK("i2c released", 4'hF, line_state[5:2])
    $display("i2c test done");
  endtask
  // Master clock half period for every multiplier.
  task automatic t_clk();
    int n;
    logic v;
    for (int m = 0; m < 4; m++) begin
      cfg(2'h0, 6'h00, 6'h3F, m[1:0]);
      repeat (70) @(negedge clk);
      for (int h = 0; h < 2; h++) begin
        v = master_clock_output;
        n = 0;
        while (master_clock_output === v && n < 40) begin
          @(negedge clk);
          n++;
        end
        if (n == 40) give_up();
      end
      `CHK("clock half period", 16 >> m, n)
    end
    $display("clock test done");
  endtask
  // Main sequence.
  initial begin
    t_boot(1'b0, 1'b0, 1'b0);
    t_gpio();
    t_spi();
    t_i2c();
    t_boot(1'b1, 1'b0, 1'b0);
    t_boot(1'b1, 1'b1, 1'b1);
    t_clk();
    end_of_test();
  end
endmodule
